// file: rtl/spc_consts.vh
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// clock and link rates
`define SPC_CLK_HZ      125000000
`define SPC_CON_BAUD    9600
`define SPC_BAUD_1200   1200
`define SPC_BAUD_2400   2400
`define SPC_BAUD_9600   9600
`define SPC_DIV_W       17
// self-test hold-off, seconds
`define SPC_SELFTEST_S  30

// ascii characters used by the console
`define SPC_CH_CR       8'h0d
`define SPC_CH_QUEST    8'h3f
`define SPC_CH_GT       8'h3e
`define SPC_CH_EQ       8'h3d
`define SPC_CH_A        8'h41
`define SPC_CH_D        8'h44
`define SPC_CH_J        8'h4a
`define SPC_CH_P        8'h50
`define SPC_CH_Q        8'h51
`define SPC_CH_ZERO     8'h30

// protocol codes (second and third digit)
`define SPC_PROTO_JMP   3'h0
`define SPC_PROTO_1200A 3'h1
`define SPC_PROTO_9600A 3'h2
`define SPC_PROTO_2400  3'h3
`define SPC_PROTO_1200B 3'h4
`define SPC_PROTO_9600B 3'h5
// resolution codes (first digit)
`define SPC_RES_JMP     2'h0
`define SPC_RES_100FT   2'h1
`define SPC_RES_10FT    2'h2
// highest legal digit per position
`define SPC_RES_MAX     2'h2
`define SPC_PRI_MAX     3'h5
`define SPC_SEC_MAX     3'h4

`endif

// file: rtl/spc_uart_tx.v
`timescale 1ns/10ps
`default_nettype none
`include "spc_consts.vh"

// 8n1 transmitter with a run-time bit period
module spc_uart_tx (
  // clock and reset
  input  wire                  i_core_clk,
  input  wire                  i_srst,
  // control
  input  wire                  i_en,
  input  wire [`SPC_DIV_W-1:0] i_div,
  // byte stream
  input  wire [7:0]            i_data,
  input  wire                  i_valid,
  output wire                  o_ready,
  // line
  output reg                   o_txd
);

  reg [9:0]            shift;
  reg [3:0]            bits_left;
  reg [`SPC_DIV_W-1:0] baud_cnt;

  assign o_ready = i_en && (bits_left == 4'h0);

  // period is latched per bit, so a rate change never splits a bit
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      shift     <= 10'h3ff;
      bits_left <= 4'h0;
      baud_cnt  <= {`SPC_DIV_W{1'b0}};
      o_txd     <= 1'b1;
    end else if (bits_left == 4'h0) begin
      o_txd <= 1'b1;
      if (o_ready && i_valid) begin
        shift     <= {1'b1, i_data, 1'b0};
        bits_left <= 4'ha;
        baud_cnt  <= i_div - 1'b1;
        o_txd     <= 1'b0;
      end
    end else if (baud_cnt != {`SPC_DIV_W{1'b0}}) begin
      baud_cnt <= baud_cnt - 1'b1;
    end else begin
      shift     <= {1'b1, shift[9:1]};
      bits_left <= bits_left - 1'b1;
      baud_cnt  <= i_div - 1'b1;
      o_txd     <= (bits_left == 4'h1) ? 1'b1 : shift[1];
    end
  end

endmodule // spc_uart_tx
`default_nettype wire

// file: rtl/spc_console.v
`timescale 1ns/10ps
`default_nettype none
`include "spc_consts.vh"

// Function
// - console link is 9600 baud, eight data bits, no parity, one stop bit.
// - altitude serial output held off for thirty second self-test after reset.
// - bare carriage return answers idle prompt plus present altitude.
// - adjust command with carriage return enters adjustment mode, answers adjust prompt.
// - in adjustment, port query with carriage return reports three config digits.
// - first digit picks resolution: jumpers, 100 foot or 10 foot.
// - second digit picks primary protocol and its 1200, 2400 or 9600 rate.
// - third digit picks secondary protocol, codes zero to four only.
// - a zero digit makes that setting follow the jumper inputs.
// - any grounded protocol jumper overrides software protocol settings.
// - differential output mirrors the primary serial output exactly.
// - both transmit ports run independent protocols at their own rates.
// - parallel output disabled unless altitude reporting mode and altitude enable.
// - in adjustment, port command with three legal digits stores them as new configuration.
// - jumper pin pair selects default or one of three other protocols.
module spc_console #(
  parameter [35:0] SELFTEST_CYC = 36'd30 * 36'd125000000
) (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_srst,
  // console link
  input  wire        i_cal_rxd,
  output wire        o_console_txd,
  // protocol and resolution jumpers, low when grounded
  input  wire        i_jmp_res_n,
  input  wire        i_jmp_a_n,
  input  wire        i_jmp_b_n,
  // altitude sources
  input  wire [39:0] i_alt_ascii,
  input  wire [10:0] i_alt_code,
  // parallel port control and data
  input  wire        i_mode_c,
  input  wire        i_alt_enable,
  output reg  [10:0] o_par_alt,
  // primary altitude byte stream
  input  wire [7:0]  i_pri_data,
  input  wire        i_pri_valid,
  output wire        o_pri_ready,
  // secondary altitude byte stream
  input  wire [7:0]  i_sec_data,
  input  wire        i_sec_valid,
  output wire        o_sec_ready,
  // serial lines
  output wire        o_primary_serial_out,
  output wire        o_secondary_serial_out,
  output wire        o_diff_out,
  // effective settings and status
  output reg  [2:0]  o_pri_proto,
  output reg  [2:0]  o_sec_proto,
  output reg         o_res_10ft,
  output reg         o_selftest_done,
  output reg         o_adjust_mode,
  // non-volatile configuration store
  input  wire [1:0]  i_nv_res,
  input  wire [2:0]  i_nv_pri,
  input  wire [2:0]  i_nv_sec,
  output reg         o_nv_we,
  output reg  [1:0]  o_cfg_res,
  output reg  [2:0]  o_cfg_pri,
  output reg  [2:0]  o_cfg_sec
);

  // rounded bit periods, worked out at integer width, then cut to the divider width
  localparam integer          DIV_1200_I = (`SPC_CLK_HZ + `SPC_BAUD_1200 / 2) / `SPC_BAUD_1200;
  localparam integer          DIV_2400_I = (`SPC_CLK_HZ + `SPC_BAUD_2400 / 2) / `SPC_BAUD_2400;
  localparam integer          DIV_9600_I = (`SPC_CLK_HZ + `SPC_BAUD_9600 / 2) / `SPC_BAUD_9600;
  localparam integer          DIV_CON_I  = (`SPC_CLK_HZ + `SPC_CON_BAUD / 2) / `SPC_CON_BAUD;
  localparam [`SPC_DIV_W-1:0] DIV_1200   = DIV_1200_I[`SPC_DIV_W-1:0];
  localparam [`SPC_DIV_W-1:0] DIV_2400   = DIV_2400_I[`SPC_DIV_W-1:0];
  localparam [`SPC_DIV_W-1:0] DIV_9600   = DIV_9600_I[`SPC_DIV_W-1:0];
  localparam [`SPC_DIV_W-1:0] DIV_CON    = DIV_CON_I[`SPC_DIV_W-1:0];
  localparam [`SPC_DIV_W-1:0] DIV_HALF = DIV_CON / 2;

  // receiver states, one-hot
  localparam [3:0] RX_IDLE  = 4'h1;
  localparam [3:0] RX_START = 4'h2;
  localparam [3:0] RX_DATA  = 4'h4;
  localparam [3:0] RX_STOP  = 4'h8;

  // bit period for a protocol code
  function [`SPC_DIV_W-1:0] rate_div;
    input [2:0] code;
    begin
      case (code)
        `SPC_PROTO_2400:  rate_div = DIV_2400;
        `SPC_PROTO_9600A: rate_div = DIV_9600;
        `SPC_PROTO_9600B: rate_div = DIV_9600;
        default:          rate_div = DIV_1200;
      endcase
    end
  endfunction

  // two-flop synchronisers for pins
  reg [1:0] rxd_sync;
  reg [1:0] jr_sync;
  reg [1:0] ja_sync;
  reg [1:0] jb_sync;
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      rxd_sync <= 2'h3;
      jr_sync  <= 2'h3;
      ja_sync  <= 2'h3;
      jb_sync  <= 2'h3;
    end else begin
      rxd_sync <= {rxd_sync[0], i_cal_rxd};
      jr_sync  <= {jr_sync[0], i_jmp_res_n};
      ja_sync  <= {ja_sync[0], i_jmp_a_n};
      jb_sync  <= {jb_sync[0], i_jmp_b_n};
    end
  end

  // self-test hold-off counter
  reg [35:0] st_cnt;
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      st_cnt          <= 36'h0;
      o_selftest_done <= 1'b0;
    end else if (!o_selftest_done) begin
      st_cnt          <= st_cnt + 36'h1;
      o_selftest_done <= (st_cnt >= SELFTEST_CYC - 36'h1);
    end
  end

  // parallel port: low during self-test, gated by transponder controls
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_par_alt <= 11'h000;
    end else begin
      o_par_alt <= (o_selftest_done && i_mode_c && i_alt_enable) ? i_alt_code : 11'h000;
    end
  end

  // console receiver, mid-bit sampling
  reg [3:0]            rx_state;
  reg [`SPC_DIV_W-1:0] rx_cnt;
  reg [2:0]            rx_bit;
  reg [7:0]            rx_shift;
  reg                  rx_stb;
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= {`SPC_DIV_W{1'b0}};
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      rx_stb   <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (rx_cnt != {`SPC_DIV_W{1'b0}}) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        case (rx_state)
          RX_IDLE: begin
            if (!rxd_sync[1]) begin
              rx_state <= RX_START;
              rx_cnt   <= DIV_HALF;
            end
          end
          RX_START: begin
            // a glitch shorter than half a bit is dropped
            rx_state <= rxd_sync[1] ? RX_IDLE : RX_DATA;
            rx_cnt   <= DIV_CON - 1'b1;
            rx_bit   <= 3'h0;
          end
          RX_DATA: begin
            rx_shift <= {rxd_sync[1], rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            rx_cnt   <= DIV_CON - 1'b1;
            if (rx_bit == 3'h7) begin
              rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            rx_stb   <= rxd_sync[1]; // framing error drops the byte
            rx_state <= RX_IDLE;
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // command parser and reply builder
  reg [7:0]  cmd_buf [0:3];
  reg [2:0]  cmd_cnt;
  reg        q_seen;
  reg [63:0] resp_sr;
  reg [3:0]  resp_cnt;
  wire       con_ready;
  wire [7:0] rx_byte = rx_shift;
  wire [7:0] dg_res  = cmd_buf[1] - `SPC_CH_ZERO;
  wire [7:0] dg_pri  = cmd_buf[2] - `SPC_CH_ZERO;
  wire [7:0] dg_sec  = cmd_buf[3] - `SPC_CH_ZERO;
  wire       dg_ok   = (dg_res <= {6'h00, `SPC_RES_MAX}) &&
                       (dg_pri <= {5'h00, `SPC_PRI_MAX}) &&
                       (dg_sec <= {5'h00, `SPC_SEC_MAX});
  wire       is_adj  = (cmd_cnt == 3'h3) && (cmd_buf[0] == `SPC_CH_A) &&
                       (cmd_buf[1] == `SPC_CH_D) && (cmd_buf[2] == `SPC_CH_J);
  wire       is_p    = (cmd_buf[0] == `SPC_CH_P);
  wire [63:0] idle_msg = {`SPC_CH_QUEST, `SPC_CH_GT, i_alt_ascii, `SPC_CH_CR};
  wire [63:0] adj_msg  = {`SPC_CH_A, `SPC_CH_EQ, 48'h0};
  wire [63:0] cfg_msg  = {6'h0c, o_cfg_res, 5'h06, o_cfg_pri, 5'h06, o_cfg_sec,
                          `SPC_CH_CR, 32'h0};

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      cmd_cnt       <= 3'h0;
      q_seen        <= 1'b0;
      resp_sr       <= 64'h0;
      resp_cnt      <= 4'h0;
      o_adjust_mode <= 1'b0;
      o_nv_we       <= 1'b0;
      o_cfg_res     <= i_nv_res;
      o_cfg_pri     <= i_nv_pri;
      o_cfg_sec     <= i_nv_sec;
      cmd_buf[0]    <= 8'h00;
      cmd_buf[1]    <= 8'h00;
      cmd_buf[2]    <= 8'h00;
      cmd_buf[3]    <= 8'h00;
    end else begin
      o_nv_we <= 1'b0;
      if (con_ready && resp_cnt != 4'h0) begin
        resp_sr  <= {resp_sr[55:0], 8'h00};
        resp_cnt <= resp_cnt - 4'h1;
      end
      if (rx_stb) begin
        q_seen <= 1'b0;
        if (o_adjust_mode && rx_byte == `SPC_CH_Q) begin
          // two q in a row leave adjustment
          q_seen  <= !q_seen;
          cmd_cnt <= 3'h0;
          if (q_seen) begin
            o_adjust_mode <= 1'b0;
          end
        end else if (rx_byte == `SPC_CH_CR) begin
          cmd_cnt <= 3'h0;
          // a new reply is dropped while one is still going out
          if (resp_cnt == 4'h0) begin
            if (!o_adjust_mode) begin
              if (is_adj) begin
                o_adjust_mode <= 1'b1;
                resp_sr       <= adj_msg;
                resp_cnt      <= 4'h2;
              end else begin
                resp_sr  <= idle_msg;
                resp_cnt <= 4'h8;
              end
            end else if (cmd_cnt == 3'h1 && is_p) begin
              resp_sr  <= cfg_msg;
              resp_cnt <= 4'h4;
            end else begin
              resp_sr  <= adj_msg;
              resp_cnt <= 4'h2;
            end
          end
          if (o_adjust_mode && cmd_cnt == 3'h4 && is_p && dg_ok) begin
            o_cfg_res <= dg_res[1:0];
            o_cfg_pri <= dg_pri[2:0];
            o_cfg_sec <= dg_sec[2:0];
            o_nv_we   <= 1'b1;
          end
        end else if (cmd_cnt < 3'h4) begin
          cmd_buf[cmd_cnt[1:0]] <= rx_byte;
          cmd_cnt               <= cmd_cnt + 3'h1;
        end else begin
          cmd_cnt <= 3'h5; // too long, answered as unknown
        end
      end
    end
  end

  // effective settings: grounded jumpers win, zero digits defer to them
  wire       jmp_a   = !ja_sync[1];
  wire       jmp_b   = !jb_sync[1];
  wire       jmp_any = jmp_a || jmp_b;
  wire [2:0] jmp_proto = (jmp_a && jmp_b) ? `SPC_PROTO_1200B :
                         jmp_a ? `SPC_PROTO_9600A :
                         jmp_b ? `SPC_PROTO_2400 : `SPC_PROTO_1200A;
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pri_proto <= `SPC_PROTO_1200A;
      o_sec_proto <= `SPC_PROTO_1200A;
      o_res_10ft  <= 1'b0;
    end else begin
      o_pri_proto <= (jmp_any || o_cfg_pri == `SPC_PROTO_JMP) ? jmp_proto : o_cfg_pri;
      o_sec_proto <= (jmp_any || o_cfg_sec == `SPC_PROTO_JMP) ? jmp_proto : o_cfg_sec;
      o_res_10ft  <= (!jr_sync[1] || o_cfg_res == `SPC_RES_JMP) ? !jr_sync[1] :
                     (o_cfg_res == `SPC_RES_10FT);
    end
  end

  // console answer transmitter
  spc_uart_tx u_con_tx (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_en       (1'b1),
    .i_div      (DIV_CON),
    .i_data     (resp_sr[63:56]),
    .i_valid    (resp_cnt != 4'h0),
    .o_ready    (con_ready),
    .o_txd      (o_console_txd)
  );

  // two independent altitude ports, each at its own rate
  spc_uart_tx u_pri_tx (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_en       (o_selftest_done),
    .i_div      (rate_div(o_pri_proto)),
    .i_data     (i_pri_data),
    .i_valid    (i_pri_valid),
    .o_ready    (o_pri_ready),
    .o_txd      (o_primary_serial_out)
  );

  spc_uart_tx u_sec_tx (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_en       (o_selftest_done),
    .i_div      (rate_div(o_sec_proto)),
    .i_data     (i_sec_data),
    .i_valid    (i_sec_valid),
    .o_ready    (o_sec_ready),
    .o_txd      (o_secondary_serial_out)
  );

  assign o_diff_out = o_primary_serial_out;

endmodule // spc_console
`default_nettype wire

// file: testbench/spc_props_properties.sv
`timescale 1ns/10ps
`default_nettype none

// port-level checks for the console block
module spc_props #(
  parameter [35:0] SELFTEST_CYC = 36'd100
) (
  input wire        i_core_clk,
  input wire        i_srst,
  input wire        i_jmp_res_n,
  input wire        i_jmp_a_n,
  input wire        i_jmp_b_n,
  input wire [10:0] i_alt_code,
  input wire        i_mode_c,
  input wire        i_alt_enable,
  input wire [10:0] o_par_alt,
  input wire        i_pri_valid,
  input wire        o_pri_ready,
  input wire        i_sec_valid,
  input wire        o_sec_ready,
  input wire        o_primary_serial_out,
  input wire        o_secondary_serial_out,
  input wire        o_diff_out,
  input wire [2:0]  o_pri_proto,
  input wire [2:0]  o_sec_proto,
  input wire        o_res_10ft,
  input wire        o_selftest_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // cycles since reset, saturating so it cannot wrap in a long run
  reg [35:0] cnt;
  always @(posedge i_core_clk) begin
    if (i_srst) cnt <= 36'h0;
    else if (cnt != SELFTEST_CYC + 36'h4) cnt <= cnt + 36'h1;
  end

  chk_diff_mirror: assert property (o_diff_out == o_primary_serial_out)
    else $error("diff line differs from primary line");
  chk_par_gate: assert property (!i_mode_c || !i_alt_enable |=> o_par_alt == 11'h0)
    else $error("parallel output not disabled");
  chk_par_pass: assert property (o_selftest_done && i_mode_c && i_alt_enable
    |=> o_par_alt == $past(i_alt_code))
    else $error("parallel output not following code");
  chk_selftest_hold: assert property (!o_selftest_done |-> !o_pri_ready && !o_sec_ready
    && o_primary_serial_out && o_secondary_serial_out)
    else $error("serial output during self test");
  chk_selftest_time: assert property ($rose(o_selftest_done)
    |-> cnt >= SELFTEST_CYC - 36'h1 && cnt <= SELFTEST_CYC + 36'h2)
    else $error("self test length wrong");
  chk_jmp_both: assert property ((!i_jmp_a_n && !i_jmp_b_n) [*5]
    |-> o_pri_proto == 3'h4 && o_sec_proto == 3'h4)
    else $error("both jumpers not obeyed");
  chk_jmp_a_only: assert property ((!i_jmp_a_n && i_jmp_b_n) [*5]
    |-> o_pri_proto == 3'h2 && o_sec_proto == 3'h2)
    else $error("single jumper not obeyed");
  chk_res_jumper: assert property (!i_jmp_res_n [*5] |-> o_res_10ft)
    else $error("resolution jumper not obeyed");
  chk_pri_start: assert property (i_pri_valid && o_pri_ready
    |=> !o_primary_serial_out && !o_pri_ready)
    else $error("primary frame did not start");
  chk_sec_start: assert property (i_sec_valid && o_sec_ready
    |=> !o_secondary_serial_out && !o_sec_ready)
    else $error("secondary frame did not start");
endmodule // spc_props

bind spc_console spc_props #(.SELFTEST_CYC(SELFTEST_CYC)) u_props (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_jmp_res_n(i_jmp_res_n),
  .i_jmp_a_n(i_jmp_a_n), .i_jmp_b_n(i_jmp_b_n), .i_alt_code(i_alt_code),
  .i_mode_c(i_mode_c), .i_alt_enable(i_alt_enable), .o_par_alt(o_par_alt),
  .i_pri_valid(i_pri_valid), .o_pri_ready(o_pri_ready), .i_sec_valid(i_sec_valid),
  .o_sec_ready(o_sec_ready), .o_primary_serial_out(o_primary_serial_out),
  .o_secondary_serial_out(o_secondary_serial_out), .o_diff_out(o_diff_out),
  .o_pri_proto(o_pri_proto), .o_sec_proto(o_sec_proto), .o_res_10ft(o_res_10ft),
  .o_selftest_done(o_selftest_done));
`default_nettype wire

// file: testbench/spc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// terminal side: sends one byte, then times and samples the answer
module spc_host_model #(
  parameter integer DIV = 13021
) (
  input  wire        i_core_clk,
  input  wire        i_start,
  input  wire [7:0]  i_byte,
  input  wire        i_txd,
  output reg         o_rxd,
  output reg         o_done,
  output reg  [1:0]  o_bits,
  output reg  [31:0] o_lat
);
  integer k;
  initial begin
    o_rxd = 1'b1;
    o_done = 1'b0;
    o_bits = 2'h0;
    o_lat = 32'h0;
    @(posedge i_start);
    @(negedge i_core_clk);
    o_rxd = 1'b0;
    repeat (DIV) @(negedge i_core_clk);
    // lsb first, no parity, stop then idle high
    for (k = 0; k < 8; k = k + 1) begin
      o_rxd = i_byte[k];
      repeat (DIV) @(negedge i_core_clk);
    end
    o_rxd = 1'b1;
    o_lat = 9 * DIV;
    // bounded wait so a silent device cannot hang the model
    while (i_txd === 1'b1 && o_lat < 12 * DIV) begin
      @(negedge i_core_clk);
      o_lat = o_lat + 1;
    end
    repeat (DIV + DIV / 2) @(negedge i_core_clk);
    o_bits[0] = i_txd;
    repeat (DIV) @(negedge i_core_clk);
    o_bits[1] = i_txd;
    o_done = 1'b1;
  end
endmodule // spc_host_model
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "spc_consts.vh"

module tb;
  localparam integer D = 13021; // 9600 baud bit period
  reg        clk = 1'b0, srst = 1'b1, res_n = 1'b1, a_n = 1'b1, b_n = 1'b1;
  reg        mode_c = 1'b0, alt_en = 1'b0, pri_v = 1'b0, sec_v = 1'b0, go = 1'b0;
  reg [10:0] code = 11'h0;
  reg [7:0]  pri_d = 8'ha5, sec_d = 8'hc3;
  reg [9:0]  frame;
  reg [1:0]  nv_res = 2'h0;
  reg [2:0]  nv_pri = 3'h0, nv_sec = 3'h0;
  wire        rxd, ctxd, pri_rdy, sec_rdy, pso, sso, diff, r10, st_done, adjust_command, nv_we, hdone;
  wire [10:0] par;
  wire [2:0]  ppro, spro, cpri, csec;
  wire [1:0]  cres, hbits;
  wire [31:0] hlat;
  integer n_fail = 0, check_count = 0, seed = 44, cyc = 0, k, i;

  spc_console #(.SELFTEST_CYC(36'd100)) u_dut (
    .i_core_clk(clk), .i_srst(srst), .i_cal_rxd(rxd), .o_console_txd(ctxd),
    .i_jmp_res_n(res_n), .i_jmp_a_n(a_n), .i_jmp_b_n(b_n), .i_alt_ascii(40'h3031323334),
    .i_alt_code(code), .i_mode_c(mode_c), .i_alt_enable(alt_en), .o_par_alt(par),
    .i_pri_data(pri_d), .i_pri_valid(pri_v), .o_pri_ready(pri_rdy),
    .i_sec_data(sec_d), .i_sec_valid(sec_v), .o_sec_ready(sec_rdy),
    .o_primary_serial_out(pso), .o_secondary_serial_out(sso), .o_diff_out(diff),
    .o_pri_proto(ppro), .o_sec_proto(spro), .o_res_10ft(r10), .o_selftest_done(st_done),
    .o_adjust_mode(adjust_command), .i_nv_res(nv_res), .i_nv_pri(nv_pri), .i_nv_sec(nv_sec),
    .o_nv_we(nv_we), .o_cfg_res(cres), .o_cfg_pri(cpri), .o_cfg_sec(csec));

  spc_host_model #(.DIV(D)) u_host (
    .i_core_clk(clk), .i_start(go), .i_byte(`SPC_CH_CR), .i_txd(ctxd),
    .o_rxd(rxd), .o_done(hdone), .o_bits(hbits), .o_lat(hlat));

  initial begin
    forever #4 clk = ~clk;
  end

  task print_verdict;
    begin
      if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  task check(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // effective protocol: any grounded jumper or a zero digit defers to jumpers
  function [2:0] eff(input an, input bn, input [2:0] dg);
    reg [2:0] j;
    begin
      j = (!an && !bn) ? 3'h4 : !bn ? 3'h3 : !an ? 3'h2 : 3'h1;
      eff = (!an || !bn || dg == 3'h0) ? j : dg;
    end
  endfunction

  // hang guard, well above the longest serial exchange
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 200000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end

  initial begin
    for (k = 0; k < 3; k = k + 1) begin
      srst = 1'b1;
      nv_res = (k == 2) ? 2'h2 : 2'($unsigned($random(seed)) % 3);
      nv_pri = (k == 2) ? 3'h2 : 3'($unsigned($random(seed)) % 6);
      nv_sec = (k == 2) ? 3'h3 : 3'($unsigned($random(seed)) % 5);
      repeat (20) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      check("cfg", {cres, cpri, csec}, {nv_res, nv_pri, nv_sec});
      repeat (90) @(negedge clk);
      check("selftest_early", st_done, 1'b0);
      repeat (15) @(negedge clk);
      check("selftest_done", st_done, 1'b1);
      for (i = 0; i < 12; i = i + 1) begin
        {res_n, a_n, b_n, mode_c, alt_en} = 5'($random(seed));
        code = 11'($random(seed));
        if (k == 2) {res_n, a_n, b_n} = 3'h7;
        repeat (5) @(negedge clk);
        check("pri_proto", ppro, eff(a_n, b_n, nv_pri));
        check("sec_proto", spro, eff(a_n, b_n, nv_sec));
        check("res", r10, (!res_n || nv_res == 2'h0) ? !res_n : nv_res == 2'h2);
        check("par_alt", par, (mode_c && alt_en) ? code : 11'h0);
      end
    end
    // both ports start together while the terminal sends a carriage return
    frame = {1'b1, pri_d, 1'b0};
    go = 1'b1;
    pri_v = 1'b1;
    sec_v = 1'b1;
    @(negedge clk);
    pri_v = 1'b0;
    sec_v = 1'b0;
    check("pri_ready", pri_rdy, 1'b0);
    repeat (D / 2) @(negedge clk);
    for (i = 0; i < 10; i = i + 1) begin
      check("pri_bit", pso, frame[i]);
      check("diff_bit", diff, frame[i]);
      if (i == 1 || i == 4) check("sec_bit", sso, i == 4);
      if (i < 9) repeat (D) @(negedge clk);
    end
    check("pri_busy", pri_rdy, 1'b0);
    for (i = 0; i < 40000 && hdone !== 1'b1; i = i + 1) @(negedge clk);
    check("reply_bits", hbits, 2'h3);
    check("reply_lat", hlat >= 9 * D + D / 2 - 2 && hlat <= 9 * D + D / 2 + 12, 1'b1);
    check("adjust", adjust_command, 1'b0);
    print_verdict;
  end
endmodule // tb
`default_nettype wire
